// >>> rtl/sfps_regs.vh
// constants of the serial flash program, erase and sleep sequencer
// Summary of operation
// - page program 02h accepted only while write unlock latch is set
// - data past page end wraps to the page's first byte
// - over 256 data bytes: only the final 256 are programmed
// - fewer than 256 bytes: only addressed bytes change
// - program discarded unless select rises on a byte boundary
// - select rise starts timed cycle; busy set; unlock cleared as busy drops at its end
// - program into protected page is refused
// - 20h erases the addressed 4-Kbyte region to all ones
// - D8h erases the addressed 64-Kbyte block to all ones
// - region erase runs only if select rises right after address
// - region erase refused when region is protected
// - C7h or 60h alone erases whole array, after unlock
// - whole-array erase only when all protect bits are zero
// - B9h enters deep sleep after a delay; only wake accepted then
// - deep sleep rejected while a timed cycle runs
// - device always starts up in standby, not deep sleep
// - select high deselects into standby when no cycle runs
// - ABh with select rise wakes after the wake delay
// - ABh plus three dummy bytes shifts the 8-bit ID out repeatedly
// - wake via ID read returns to standby after second wake delay
// - wake or ID command not decoded while a timed cycle runs
`ifndef SFPS_REGS_VH
`define SFPS_REGS_VH
`define SFPS_OP_UNLOCK 8'h06
`define SFPS_OP_PROGRAM 8'h02
`define SFPS_OP_SMALL_CLR 8'h20
`define SFPS_OP_LARGE_CLR 8'hD8
`define SFPS_OP_ARRAY_CLR_A 8'hC7
`define SFPS_OP_ARRAY_CLR_B 8'h60
`define SFPS_OP_SLEEP 8'hB9
`define SFPS_OP_WAKE 8'hAB
`define SFPS_ADDR_BYTES 16'h0003
`define SFPS_ID_DUMMY 16'h0003
`define SFPS_PAGE_BYTES 256
`define SFPS_CLK_NS 100
`define SFPS_PP_US 1300
`define SFPS_PP_CYC ((`SFPS_PP_US * 1000) / `SFPS_CLK_NS)
`define SFPS_SMALL_CLR_US 90000
`define SFPS_SMALL_CLR_CYC ((`SFPS_SMALL_CLR_US * 1000) / `SFPS_CLK_NS)
`define SFPS_LARGE_CLR_US 500000
`define SFPS_LARGE_CLR_CYC ((`SFPS_LARGE_CLR_US * 1000) / `SFPS_CLK_NS)
`define SFPS_ARRAY_CLR_US 8000000
`define SFPS_ARRAY_CLR_CYC ((`SFPS_ARRAY_CLR_US * 1000) / `SFPS_CLK_NS)
`define SFPS_SLEEP_US 3
`define SFPS_SLEEP_CYC ((`SFPS_SLEEP_US * 1000 + `SFPS_CLK_NS - 1) / `SFPS_CLK_NS)
`define SFPS_WAKE_US 3
`define SFPS_WAKE_CYC ((`SFPS_WAKE_US * 1000 + `SFPS_CLK_NS - 1) / `SFPS_CLK_NS)
`define SFPS_WAKE_ID_US 2
`define SFPS_WAKE_ID_CYC ((`SFPS_WAKE_ID_US * 1000 + `SFPS_CLK_NS - 1) / `SFPS_CLK_NS)
`endif

// >>> rtl/sfps_sync.v
// two-flop synchroniser for the serial pins
`timescale 1ns/1ps
module sfps_sync #(
    parameter W = 3,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] asyncIn,
    output reg [W-1:0] syncOut
);
    reg [W-1:0] meta_q;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // idle pin levels, so release gives no false edge
            meta_q <= RST_VAL;
            syncOut <= RST_VAL;
        end
        else
        begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule

// >>> rtl/sfps_sequencer.v
// command sequencer of the serial flash program, erase and sleep logic
`timescale 1ns/1ps
`include "sfps_regs.vh"
module sfps_sequencer #(
    parameter [7:0] DEVICE_ID = 8'h5A, // arbitrary value
    parameter [31:0] PP_CYC = `SFPS_PP_CYC,
    parameter [31:0] SMALL_CLR_CYC = `SFPS_SMALL_CLR_CYC,
    parameter [31:0] LARGE_CLR_CYC = `SFPS_LARGE_CLR_CYC,
    parameter [31:0] ARRAY_CLR_CYC = `SFPS_ARRAY_CLR_CYC,
    parameter [31:0] SLEEP_CYC = `SFPS_SLEEP_CYC,
    parameter [31:0] WAKE_CYC = `SFPS_WAKE_CYC,
    parameter [31:0] WAKE_ID_CYC = `SFPS_WAKE_ID_CYC
) (
    input wire clk,
    input wire rst_n,
    input wire chipSelN,
    input wire serialClk,
    input wire serialIn,
    output reg serialOut,
    output reg serialOutEn,
    input wire [2:0] protectRangeBits,
    output wire busyFlag,
    output wire writeUnlockLatch,
    output wire deepSleep,
    output reg progStart,
    output reg eraseStart,
    output reg [1:0] eraseKind,
    output reg [23:0] opAddr,
    output reg [7:0] pageStartIdx,
    output reg [8:0] pageByteCnt,
    output reg [2047:0] pageData,
    output reg [255:0] pageMask
);
    // ****************************************************************
    // pin synchronisers and edge detection
    // ****************************************************************
    wire [2:0] pinSync;
    reg sclkPrev_q;
    reg csPrev_q;
    wire csN = pinSync[2];
    wire sclk = pinSync[1];
    wire sdi = pinSync[0];
    wire sclkRise = sclk & ~sclkPrev_q;
    wire sclkFall = ~sclk & sclkPrev_q;
    wire csRise = csN & ~csPrev_q;

    sfps_sync #(.W(3), .RST_VAL(3'b100)) uSync (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn({chipSelN, serialClk, serialIn}),
        .syncOut(pinSync)
    );

    // ****************************************************************
    // protection decode
    // ****************************************************************
    // protected top fraction of array: 1/16 up to all, by 64-Kbyte blocks
    function isProtected;
        input [2:0] bp;
        input [23:0] addr;
        reg [3:0] blk;
        begin
            blk = addr[19:16];
            case (bp)
                3'd0: isProtected = 1'b0;
                3'd1: isProtected = (blk == 4'hF);
                3'd2: isProtected = (blk >= 4'hE);
                3'd3: isProtected = (blk >= 4'hC);
                3'd4: isProtected = (blk >= 4'h8);
                default: isProtected = 1'b1;
            endcase
        end
    endfunction

    // ****************************************************************
    // serial shift state
    // ****************************************************************
    localparam KIND_SMALL = 2'd0;
    localparam KIND_LARGE = 2'd1;
    localparam KIND_ARRAY = 2'd2;

    localparam ST_IDLE = 3'd0;
    localparam ST_BUSY = 3'd1;
    localparam ST_SLEEP_WAIT = 3'd2;
    localparam ST_SLEEP = 3'd3;
    localparam ST_WAKE_WAIT = 3'd4;

    reg [2:0] state_q;
    reg [31:0] timer_q;
    reg unlock_q;
    reg selected_q;
    reg [2:0] bitCnt_q;
    reg [7:0] shift_q;
    reg [7:0] opcode_q;
    reg [15:0] byteCnt_q;
    reg [7:0] wrPtr_q;
    reg [7:0] idShift_q;
    reg idOut_q;

    wire [7:0] inByte = {shift_q[6:0], sdi};
    wire boundary = (bitCnt_q == 3'd0);
    wire active = (state_q == ST_IDLE) || (state_q == ST_SLEEP);
    wire asleep = (state_q == ST_SLEEP);
    wire [15:0] addrEnd = `SFPS_ADDR_BYTES + 16'h0001;
    wire [15:0] idStart = `SFPS_ID_DUMMY + 16'h0001;

    assign busyFlag = (state_q == ST_BUSY);
    assign writeUnlockLatch = unlock_q;
    assign deepSleep = asleep || (state_q == ST_WAKE_WAIT);

    integer i;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclkPrev_q <= 1'b0;
            csPrev_q <= 1'b1;
            state_q <= ST_IDLE;
            timer_q <= 32'h0000_0000;
            unlock_q <= 1'b0;
            selected_q <= 1'b0;
            bitCnt_q <= 3'd0;
            shift_q <= 8'h00;
            opcode_q <= 8'h00;
            byteCnt_q <= 16'h0000;
            wrPtr_q <= 8'h00;
            idShift_q <= 8'h00;
            idOut_q <= 1'b0;
            serialOut <= 1'b0;
            serialOutEn <= 1'b0;
            progStart <= 1'b0;
            eraseStart <= 1'b0;
            eraseKind <= KIND_SMALL;
            opAddr <= 24'h00_0000;
            pageStartIdx <= 8'h00;
            pageByteCnt <= 9'h000;
            pageData <= {2048{1'b1}};
            pageMask <= {256{1'b0}};
        end
        else
        begin
            sclkPrev_q <= sclk;
            csPrev_q <= csN;
            progStart <= 1'b0;
            eraseStart <= 1'b0;
            if (timer_q != 32'h0000_0000)
                timer_q <= timer_q - 32'h0000_0001;

            // ********************************************************
            // self-timed states
            // ********************************************************
            case (state_q)
                ST_BUSY:
                begin
                    if (timer_q == 32'h0000_0001)
                    begin
                        state_q <= ST_IDLE;
                        unlock_q <= 1'b0;
                    end
                end
                ST_SLEEP_WAIT:
                    if (timer_q == 32'h0000_0001)
                        state_q <= ST_SLEEP;
                ST_WAKE_WAIT:
                    if (timer_q == 32'h0000_0001)
                        state_q <= ST_IDLE;
                default:
                    ;
            endcase

            // ********************************************************
            // frame start and bit capture, rising serial clock
            // ********************************************************
            if (!csN && csPrev_q)
            begin
                selected_q <= active;
                bitCnt_q <= 3'd0;
                byteCnt_q <= 16'h0000;
                wrPtr_q <= 8'h00;
                pageMask <= {256{1'b0}};
                pageByteCnt <= 9'h000;
                pageData <= {2048{1'b1}};
            end
            else if (!csN && selected_q && sclkRise)
            begin
                shift_q <= inByte;
                bitCnt_q <= bitCnt_q + 3'd1;
                if (bitCnt_q == 3'd7)
                begin
                    byteCnt_q <= byteCnt_q + 16'h0001;
                    if (byteCnt_q == 16'h0000)
                    begin
                        opcode_q <= inByte;
                        // asleep: only wake opcode stays decoded
                        if (asleep && inByte != `SFPS_OP_WAKE)
                            selected_q <= 1'b0;
                        if (inByte == `SFPS_OP_WAKE)
                            idShift_q <= DEVICE_ID;
                    end
                    else if (byteCnt_q < addrEnd)
                    begin
                        opAddr <= {opAddr[15:0], inByte};
                        if (byteCnt_q == `SFPS_ADDR_BYTES)
                            wrPtr_q <= inByte;
                    end
                    else if (opcode_q == `SFPS_OP_PROGRAM)
                    begin
                        // wrap within page; later bytes overwrite older
                        pageData[{wrPtr_q, 3'b000} +: 8] <= inByte;
                        pageMask[wrPtr_q] <= 1'b1;
                        wrPtr_q <= wrPtr_q + 8'h01;
                        if (pageByteCnt != `SFPS_PAGE_BYTES)
                            pageByteCnt <= pageByteCnt + 9'h001;
                    end
                end
            end

            // ********************************************************
            // id output, falling serial clock
            // ********************************************************
            if (!csN && selected_q && sclkFall && opcode_q ==
                `SFPS_OP_WAKE && byteCnt_q >= idStart)
            begin
                serialOutEn <= 1'b1;
                serialOut <= idShift_q[7];
                idShift_q <= {idShift_q[6:0], idShift_q[7]};
            end
            if (csN)
                serialOutEn <= 1'b0;

            // ********************************************************
            // command execution on select rising
            // ********************************************************
            if (csRise && selected_q && active)
            begin
                selected_q <= 1'b0;
                pageStartIdx <= opAddr[7:0];
                if (asleep)
                begin
                    if (opcode_q == `SFPS_OP_WAKE && boundary)
                    begin
                        state_q <= ST_WAKE_WAIT;
                        timer_q <= (byteCnt_q >= idStart) ?
                            WAKE_ID_CYC : WAKE_CYC;
                    end
                end
                else if (boundary)
                begin
                    case (opcode_q)
                        `SFPS_OP_UNLOCK:
                            if (byteCnt_q == 16'h0001)
                                unlock_q <= 1'b1;
                        `SFPS_OP_PROGRAM:
                            if (unlock_q && byteCnt_q > addrEnd &&
                                !isProtected(protectRangeBits, opAddr))
                            begin
                                state_q <= ST_BUSY;
                                timer_q <= PP_CYC;
                                progStart <= 1'b1;
                            end
                        `SFPS_OP_SMALL_CLR, `SFPS_OP_LARGE_CLR:
                            if (unlock_q && byteCnt_q == addrEnd &&
                                !isProtected(protectRangeBits, opAddr))
                            begin
                                state_q <= ST_BUSY;
                                eraseStart <= 1'b1;
                                if (opcode_q == `SFPS_OP_SMALL_CLR)
                                begin
                                    eraseKind <= KIND_SMALL;
                                    timer_q <= SMALL_CLR_CYC;
                                end
                                else
                                begin
                                    eraseKind <= KIND_LARGE;
                                    timer_q <= LARGE_CLR_CYC;
                                end
                            end
                        `SFPS_OP_ARRAY_CLR_A, `SFPS_OP_ARRAY_CLR_B:
                            if (unlock_q && byteCnt_q == 16'h0001 &&
                                protectRangeBits == 3'b000)
                            begin
                                state_q <= ST_BUSY;
                                eraseStart <= 1'b1;
                                eraseKind <= KIND_ARRAY;
                                timer_q <= ARRAY_CLR_CYC;
                            end
                        `SFPS_OP_SLEEP:
                            if (byteCnt_q == 16'h0001)
                            begin
                                state_q <= ST_SLEEP_WAIT;
                                timer_q <= SLEEP_CYC;
                            end
                        default:
                            ;
                    endcase
                end
            end
        end
    end
endmodule

// >>> testbench/sfps_seq_chk.sv
// port checker for the flash command sequencer
`timescale 1ns/1ps
module sfps_seq_chk (
    input wire clk,
    input wire rst_n,
    input wire chipSelN,
    input wire [2:0] protectRangeBits,
    input wire busyFlag,
    input wire writeUnlockLatch,
    input wire deepSleep,
    input wire serialOutEn,
    input wire progStart,
    input wire eraseStart,
    input wire [1:0] eraseKind
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ************
    // properties
    // ************
    a_prog_pulse: assert property (progStart |=> !progStart)
        else $error("program start longer than one cycle");
    a_start_unlocked: assert property
        (progStart || eraseStart |-> writeUnlockLatch)
        else $error("start without unlock latch");
    a_start_deselect: assert property (progStart || eraseStart
        |-> chipSelN && $past(chipSelN, 2))
        else $error("start while select low");
    a_busy_follows: assert property
        (progStart || eraseStart |-> ##[0:2] busyFlag)
        else $error("busy not raised after start");
    a_busy_holds: assert property ($rose(busyFlag) |-> busyFlag[*8])
        else $error("busy too short");
    a_unlock_clear: assert property
        ($fell(busyFlag) |-> ##[0:1] !writeUnlockLatch)
        else $error("unlock kept after cycle");
    a_prog_protect: assert property
        (progStart |-> protectRangeBits != 3'h7)
        else $error("program into protected page");
    a_array_protect: assert property (eraseStart && eraseKind == 2'h2
        |-> protectRangeBits == 3'h0)
        else $error("whole erase while protected");
    a_sleep_quiet: assert property
        (deepSleep |-> !progStart && !eraseStart)
        else $error("start during deep sleep");
    a_busy_no_id: assert property (busyFlag |-> !serialOutEn)
        else $error("id driven while busy");
    a_busy_no_sleep: assert property (busyFlag |-> !$rose(deepSleep))
        else $error("sleep entered while busy");
    cover property (progStart);
    cover property (eraseStart && eraseKind == 2'h2);
    cover property ($rose(deepSleep));
    cover property (serialOutEn);
endmodule
bind sfps_sequencer sfps_seq_chk u_chk (.clk(clk), .rst_n(rst_n),
    .chipSelN(chipSelN), .protectRangeBits(protectRangeBits),
    .busyFlag(busyFlag), .writeUnlockLatch(writeUnlockLatch),
    .deepSleep(deepSleep), .serialOutEn(serialOutEn),
    .progStart(progStart), .eraseStart(eraseStart),
    .eraseKind(eraseKind));

// >>> testbench/sfps_host.sv
// host controller model driving the serial flash pins
`timescale 1ns/1ps
module sfps_host (
    input wire clk,
    input wire serialOut,
    output reg chipSelN,
    output reg serialClk,
    output reg serialIn
);
    reg [15:0] rxWord;
    initial
    begin
        chipSelN = 1'b1;
        serialClk = 1'b0;
        serialIn = 1'b0;
        rxWord = 16'h0000;
    end
    // one bit per 8 clk, set while low, taken on the rise, msb first
    task bit_x(input b);
    begin
        @(negedge clk);
        serialClk = 1'b0;
        serialIn = b;
        repeat (4) @(negedge clk);
        serialClk = 1'b1;
        repeat (3) @(negedge clk);
        rxWord = {rxWord[14:0], serialOut};
    end
    endtask
    // select low for the whole frame; extra bits break the byte boundary
    task frame(input logic [7:0] q[$], input int extra, input int nRd);
        int k;
    begin
        @(negedge clk);
        chipSelN = 1'b0;
        foreach (q[i])
            for (k = 7; k >= 0; k--)
                bit_x(q[i][k]);
        for (k = 0; k < extra + nRd; k++)
            bit_x(1'b1);
        @(negedge clk);
        serialClk = 1'b0;
        repeat (2) @(negedge clk);
        chipSelN = 1'b1;
        // released line shows the inverse, never the last value
        serialIn = ~serialIn;
        repeat (8) @(negedge clk);
    end
    endtask
endmodule

// >>> testbench/sfps_sequencer_bench.sv
// self-checking bench of the flash command sequencer
`timescale 1ns/1ps
module sfps_sequencer_bench;
    localparam [7:0] DEV = 8'hC3; // arbitrary value
    reg clk = 1'b0;
    reg rst_n;
    reg [2:0] bp;
    reg [31:0] seed = 32'h0000_cb21;
    reg [1:0] lastKind = 2'h0;
    int nProg = 0;
    int nErase = 0;
    int n_errors = 0;
    int n_checks = 0;
    logic [7:0] ops[3] = '{8'h20, 8'hD8, 8'hC7};
    wire cs, sck, si, so, soEn, busyFlag, writeUnlockLatch, deepSleep;
    wire progStart, eraseStart;
    wire [1:0] eraseKind;
    wire [23:0] opAddr;
    wire [7:0] pageStartIdx;
    wire [8:0] pageByteCnt;
    wire [2047:0] pageData;
    wire [255:0] pageMask;
    always #50 clk = ~clk;
    sfps_sequencer #(.DEVICE_ID(DEV), .PP_CYC(50), .SMALL_CLR_CYC(60),
        .LARGE_CLR_CYC(70), .ARRAY_CLR_CYC(2000)) u_sfps_sequencer (
        .clk(clk), .rst_n(rst_n), .chipSelN(cs), .serialClk(sck),
        .serialIn(si), .serialOut(so), .serialOutEn(soEn),
        .protectRangeBits(bp), .busyFlag(busyFlag),
        .writeUnlockLatch(writeUnlockLatch), .deepSleep(deepSleep),
        .progStart(progStart), .eraseStart(eraseStart),
        .eraseKind(eraseKind), .opAddr(opAddr),
        .pageStartIdx(pageStartIdx), .pageByteCnt(pageByteCnt),
        .pageData(pageData), .pageMask(pageMask));
    sfps_host u_sfps_host (.clk(clk), .serialOut(so), .chipSelN(cs),
        .serialClk(sck), .serialIn(si));
    always @(posedge clk)
    begin
        if (progStart)
            nProg++;
        if (eraseStart)
        begin
            nErase++;
            lastKind <= eraseKind;
        end
    end
    // ************
    // helpers
    // ************
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [7:0] pos(input [7:0] s, input int i);
        pos = s + i[7:0];
    endfunction
    task check(input logic [255:0] seen, input logic [255:0] exp);
    begin
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %0h want %0h", $time, seen,
                exp);
        end
    end
    endtask
    task end_of_test;
    begin
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    task run(input logic [7:0] q[$], input int extra, input bit unl,
        input int dp, input int de);
        int p0;
        int e0;
    begin
        p0 = nProg;
        e0 = nErase;
        if (unl)
            u_sfps_host.frame({8'h06}, 0, 0);
        u_sfps_host.frame(q, extra, 0);
        repeat (8) @(negedge clk);
        check(nProg - p0, dp);
        check(nErase - e0, de);
    end
    endtask
    task wait_idle;
        int n;
    begin
        n = 0;
        while (busyFlag !== 1'b0 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        check(n < 3000, 1);
        check(writeUnlockLatch, 0);
    end
    endtask
    task prog(input [7:0] s, input int n);
        logic [7:0] q[$];
        logic [7:0] e[256];
        logic [255:0] m;
        int i;
    begin
        q = {8'h02, 8'h01, 8'h20, s};
        m = 0;
        for (i = 0; i < 256; i++)
            e[i] = 8'hFF;
        // later bytes overwrite earlier ones at the wrapped place
        for (i = 0; i < n; i++)
        begin
            seed = lfsr(seed);
            q.push_back(seed[7:0]);
            e[pos(s, i)] = seed[7:0];
            m[pos(s, i)] = 1'b1;
        end
        run(q, 0, 1, 1, 0);
        check(pageMask, m);
        for (i = 0; i < 256; i++)
            check(pageData[8*i+:8], e[i]);
        check(pageByteCnt, n > 256 ? 256 : n);
        check({opAddr, pageStartIdx}, {8'h01, 8'h20, s, s});
        wait_idle;
    end
    endtask
    // ************
    // sequence
    // ************
    initial
    begin
        rst_n = 1'b0;
        bp = 3'h0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check({busyFlag, deepSleep, writeUnlockLatch}, 0);
        run({8'h02, 8'h00, 8'h00, 8'h00, 8'h55}, 0, 0, 0, 0);
        prog(8'hFE, 3);
        seed = lfsr(seed);
        prog(seed[7:0], 258);
        run({8'h02, 8'h00, 8'h00, 8'h00, 8'h55}, 3, 1, 0, 0);
        bp = 3'h7;
        run({8'h02, 8'h00, 8'h00, 8'h00, 8'h55}, 0, 1, 0, 0);
        run({8'h20, 8'h00, 8'h10, 8'h00}, 0, 1, 0, 0);
        run({8'hC7}, 0, 1, 0, 0);
        bp = 3'h0;
        run({8'h20, 8'h00, 8'h10, 8'h00, 8'h00}, 0, 1, 0, 0);
        run({8'hD8, 8'h00, 8'h10}, 0, 1, 0, 0);
        run({8'hC7, 8'h00}, 0, 1, 0, 0);
        run({8'h60}, 0, 1, 0, 1);
        u_sfps_host.frame({8'hB9}, 0, 0);
        u_sfps_host.frame({8'hAB, 8'h00, 8'h00, 8'h00}, 0, 16);
        check(busyFlag, 1);
        check(u_sfps_host.rxWord, 16'h0000);
        wait_idle;
        check(deepSleep, 0);
        for (int i = 0; i < 3; i++)
        begin
            seed = lfsr(seed);
            if (i < 2)
                run({ops[i], seed[23:16], seed[15:8], seed[7:0]}, 0, 1,
                    0, 1);
            else
                run({ops[i]}, 0, 1, 0, 1);
            check(lastKind, i);
            wait_idle;
        end
        u_sfps_host.frame({8'hAB, 8'h00, 8'h00, 8'h00}, 0, 16);
        check(u_sfps_host.rxWord, {DEV, DEV});
        u_sfps_host.frame({8'hB9}, 0, 0);
        repeat (40) @(negedge clk);
        check(deepSleep, 1);
        run({8'hC7}, 0, 1, 0, 0);
        u_sfps_host.frame({8'hAB}, 0, 0);
        check(deepSleep, 1);
        repeat (40) @(negedge clk);
        check(deepSleep, 0);
        prog(8'h00, 1);
        u_sfps_host.frame({8'hB9}, 0, 0);
        repeat (40) @(negedge clk);
        u_sfps_host.frame({8'hAB, 8'h00, 8'h00, 8'h00}, 0, 16);
        check(u_sfps_host.rxWord, {DEV, DEV});
        check(deepSleep, 1);
        repeat (30) @(negedge clk);
        check(deepSleep, 0);
        end_of_test;
    end
    initial
    begin
        repeat (80000) @(posedge clk);
        n_errors++;
        end_of_test;
    end
endmodule
